// ---- design/cfr_channel_one_config.v ----
// Purpose: channel one configuration register group of a multichannel converter
// Assumes: host writes through the device control port as byte accesses, one clock
// Notes:   decoded fields are driven straight from flip-flops
// Contract
// - Bit 7 of input config picks microphone (0) or line (1) input.
// - Bits 6-5 pick differential, single-ended or pulse-density source; 3 reserved.
// - Bit 4 picks AC or DC coupling; meaningless for digital microphone.
// - Bits 3-2 pick 2.5, 10 or 20 kilo-ohm impedance; code 3 reserved.
// - Bit 0 enables range enhancer or gain loop chosen by mode register bit 3.
// - Gain bits 7-2 give gain in dB equal to code, 0 to 42.
// - Volume code zero mutes the channel.
// - Volume code 1 is -100 dB, 201 is 0 dB, 255 is 27 dB.
// - Volume resets to c9, unity gain.
// - Trim register holds upper-nibble code resetting to 8; lower nibble zero.
// - Trim code steps 0.1 dB: 0 is -0.8, 8 is 0, 15 is +0.7.
`timescale 1ns/1ps
`default_nettype none
`include "cfr_defs.vh"
module cfr_channel_one_config (
  input  wire       MCLK,
  input  wire       RST,
  input  wire       WR_EN,
  input  wire       RD_EN,
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       RANGE_GAIN_MODE_SEL,
  output reg  [7:0] RDATA,
  output reg        CH1_INPUT_KIND,
  output reg  [1:0] CH1_SOURCE_SELECT,
  output reg        CH1_COUPLING_SELECT,
  output reg  [1:0] CH1_IMPEDANCE_SELECT,
  output reg        CH1_RANGE_GAIN_ENABLE,
  output reg        RANGE_ENHANCER_EN,
  output reg        AUTOMATIC_GAIN_LOOP_EN,
  output reg  [5:0] CH1_ANALOG_GAIN,
  output reg  [7:0] CH1_VOLUME,
  output reg        CH1_MUTE,
  output reg  [8:0] CH1_VOLUME_HALF_DB,
  output reg  [3:0] CH1_ANALOG_GAIN_TRIM_CODE,
  output reg  [4:0] CH1_TRIM_TENTH_DB,
  output reg        CH1_CONFIG_RESERVED
);

  reg  [7:0] input_config_reg;
  reg  [7:0] gain_ctrl_reg;
  reg  [7:0] volume_reg;
  reg  [7:0] trim_reg;
  reg  [7:0] rdata_next;
  reg        mode_meta_reg;
  reg        mode_sync_reg;
  wire [1:0] source_code;
  wire [1:0] imp_code;
  wire [5:0] gain_code;
  wire [3:0] trim_code;

  // Field slices shared by several decodes
  assign source_code = input_config_reg[`CFR_SRC_MSB:`CFR_SRC_LSB];
  assign imp_code    = input_config_reg[`CFR_IMP_MSB:`CFR_IMP_LSB];
  assign gain_code   = gain_ctrl_reg[`CFR_GAIN_MSB:`CFR_GAIN_LSB];
  assign trim_code   = trim_reg[`CFR_TRIM_MSB:`CFR_TRIM_LSB];

  // Mode select comes from another block, treated as asynchronous
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
    end
    else
    begin
      mode_meta_reg <= RANGE_GAIN_MODE_SEL;
      mode_sync_reg <= mode_meta_reg;
    end
  end

  // Register writes
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      input_config_reg <= `CFR_RST_INPUT_CONFIG;
      gain_ctrl_reg    <= `CFR_RST_GAIN_CTRL;
      volume_reg       <= `CFR_RST_DIGITAL_VOLUME;
      trim_reg         <= `CFR_RST_GAIN_TRIM;
    end
    else if (WR_EN)
    begin
      if (ADDR == `CFR_OFF_INPUT_CONFIG)
        input_config_reg <= WDATA & `CFR_MASK_INPUT_CONFIG;
      else if (ADDR == `CFR_OFF_GAIN_CTRL)
        gain_ctrl_reg <= WDATA & `CFR_MASK_GAIN_CTRL;
      else if (ADDR == `CFR_OFF_DIGITAL_VOLUME)
        volume_reg <= WDATA;
      else if (ADDR == `CFR_OFF_GAIN_TRIM)
        trim_reg <= WDATA & `CFR_MASK_GAIN_TRIM;
    end
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    rdata_next = 8'h00;
    if (ADDR == `CFR_OFF_INPUT_CONFIG)
      rdata_next = input_config_reg;
    else if (ADDR == `CFR_OFF_GAIN_CTRL)
      rdata_next = gain_ctrl_reg;
    else if (ADDR == `CFR_OFF_DIGITAL_VOLUME)
      rdata_next = volume_reg;
    else if (ADDR == `CFR_OFF_GAIN_TRIM)
      rdata_next = trim_reg;
  end

  // Gain codes above the top step are reserved
  function gain_reserved;
    input [5:0] code;
    begin
      gain_reserved = (code > `CFR_GAIN_MAX);
    end
  endfunction

  // Reserved gain codes hold the top step rather than wrap
  function [5:0] gain_clamp;
    input [5:0] code;
    begin
      if (gain_reserved(code))
        gain_clamp = `CFR_GAIN_MAX;
      else
        gain_clamp = code;
    end
  endfunction

  // Volume code to half-dB steps above -100 dB; only 8 bits ever needed
  function [8:0] vol_half_db;
    input [7:0] code;
    begin
      if (code == `CFR_VOL_MUTE)
        vol_half_db = 9'h000;
      else
        vol_half_db = {1'b0, code} - 9'h001;
    end
  endfunction

  // Read data is registered and returns to zero between reads
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
      RDATA <= 8'h00;
    else if (RD_EN)
      RDATA <= rdata_next;
    else
      RDATA <= 8'h00;
  end

  // Input config decodes, registered so the analog side sees clean levels
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      CH1_INPUT_KIND        <= 1'b0;
      CH1_SOURCE_SELECT     <= `CFR_SRC_ANA_DIFF;
      CH1_COUPLING_SELECT   <= 1'b0;
      CH1_IMPEDANCE_SELECT  <= 2'h0;
      CH1_RANGE_GAIN_ENABLE <= 1'b0;
    end
    else
    begin
      CH1_INPUT_KIND        <= input_config_reg[`CFR_BIT_INPUT_KIND];
      CH1_SOURCE_SELECT     <= source_code;
      // coupling, forced AC for digital source
      CH1_COUPLING_SELECT   <= input_config_reg[`CFR_BIT_COUPLING] &&
                               (source_code != `CFR_SRC_PDM);
      CH1_IMPEDANCE_SELECT  <= imp_code;
      CH1_RANGE_GAIN_ENABLE <= input_config_reg[`CFR_BIT_RANGE_GAIN];
    end
  end

  // Mode bit arrives late through the synchroniser; enables lag by three edges
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      RANGE_ENHANCER_EN      <= 1'b0;
      AUTOMATIC_GAIN_LOOP_EN <= 1'b0;
    end
    else
    begin
      RANGE_ENHANCER_EN      <= input_config_reg[`CFR_BIT_RANGE_GAIN] && !mode_sync_reg;
      AUTOMATIC_GAIN_LOOP_EN <= input_config_reg[`CFR_BIT_RANGE_GAIN] && mode_sync_reg;
    end
  end

  // Gain and volume decodes
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      CH1_ANALOG_GAIN    <= 6'h00;
      CH1_VOLUME         <= `CFR_RST_DIGITAL_VOLUME;
      CH1_MUTE           <= 1'b0;
      CH1_VOLUME_HALF_DB <= `CFR_RST_VOL_HALF_DB;
    end
    else
    begin
      // gain in dB, reserved codes clamp to top
      CH1_ANALOG_GAIN    <= gain_clamp(gain_code);
      CH1_VOLUME         <= volume_reg;
      CH1_MUTE           <= (volume_reg == `CFR_VOL_MUTE);
      CH1_VOLUME_HALF_DB <= vol_half_db(volume_reg);
    end
  end

  // Trim decodes
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      CH1_ANALOG_GAIN_TRIM_CODE <= `CFR_RST_TRIM_CODE;
      CH1_TRIM_TENTH_DB  <= `CFR_RST_TRIM_TENTH_DB;
    end
    else
    begin
      CH1_ANALOG_GAIN_TRIM_CODE <= trim_code;
      // trim in tenth dB above -0.8 dB
      CH1_TRIM_TENTH_DB  <= {1'b0, trim_code};
    end
  end

  // Reserved source and impedance codes are kept as written, reserved gain codes clamp; all are flagged so firmware can spot them
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
      CH1_CONFIG_RESERVED <= 1'b0;
    else
      CH1_CONFIG_RESERVED <= (source_code == `CFR_SRC_RESERVED) ||
                             (imp_code == `CFR_IMP_RESERVED) ||
                             gain_reserved(gain_code);
  end

endmodule
`default_nettype wire

// ---- design/cfr_defs.vh ----
// Purpose: constants for the channel one configuration register group
// Assumes: byte-wide registers, byte addresses
// Notes:   definitions only
`ifndef CFR_DEFS_VH
`define CFR_DEFS_VH
`define CFR_OFF_INPUT_CONFIG   8'h3c
`define CFR_OFF_GAIN_CTRL      8'h3d
`define CFR_OFF_DIGITAL_VOLUME 8'h3e
`define CFR_OFF_GAIN_TRIM      8'h3f
`define CFR_RST_INPUT_CONFIG   8'h00
`define CFR_RST_GAIN_CTRL      8'h00
`define CFR_RST_DIGITAL_VOLUME 8'hc9
`define CFR_RST_GAIN_TRIM      8'h80
`define CFR_MASK_INPUT_CONFIG  8'hfd
`define CFR_MASK_GAIN_CTRL     8'hfc
`define CFR_MASK_GAIN_TRIM     8'hf0
`define CFR_SRC_ANA_DIFF       2'h0
`define CFR_SRC_ANA_SINGLE     2'h1
`define CFR_SRC_PDM            2'h2
`define CFR_IMP_RESERVED       2'h3
`define CFR_SRC_RESERVED       2'h3
`define CFR_GAIN_MAX           6'h2a
`define CFR_VOL_MUTE           8'h00
`define CFR_BIT_INPUT_KIND     7
`define CFR_SRC_MSB            6
`define CFR_SRC_LSB            5
`define CFR_BIT_COUPLING       4
`define CFR_IMP_MSB            3
`define CFR_IMP_LSB            2
`define CFR_BIT_RANGE_GAIN     0
`define CFR_GAIN_MSB           7
`define CFR_GAIN_LSB           2
`define CFR_TRIM_MSB           7
`define CFR_TRIM_LSB           4
`define CFR_RST_VOL_HALF_DB    9'h0c8
`define CFR_RST_TRIM_CODE      4'h8
`define CFR_RST_TRIM_TENTH_DB  5'h08
`endif

// ---- sim/cfr_channel_one_config_test.sv ----
// Purpose: self-checking bench for the channel one config registers
// Assumes: decodes settle one edge after the write edge
// Notes:   every read also checks reserved bits as zero
`timescale 1ns/1ps
`default_nettype none
module cfr_channel_one_config_test;
  logic MCLK = 0, RST = 1, WR_EN = 0, RD_EN = 0, RANGE_GAIN_MODE_SEL = 0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00;
  wire [7:0] RDATA, CH1_VOLUME;
  wire [1:0] CH1_SOURCE_SELECT, CH1_IMPEDANCE_SELECT;
  wire [5:0] CH1_ANALOG_GAIN;
  wire [8:0] CH1_VOLUME_HALF_DB;
  wire [3:0] CH1_ANALOG_GAIN_TRIM_CODE;
  wire [4:0] CH1_TRIM_TENTH_DB;
  wire CH1_INPUT_KIND, CH1_COUPLING_SELECT, CH1_RANGE_GAIN_ENABLE, RANGE_ENHANCER_EN;
  wire AUTOMATIC_GAIN_LOOP_EN, CH1_MUTE, CH1_CONFIG_RESERVED;
  integer mismatches = 0, compares = 0, i;
  cfr_channel_one_config cfr_channel_one_config_i (.*);
  always #4 MCLK = ~MCLK;
  task step; @(posedge MCLK); #1; endtask
  task chk(input [8:0] g, input [8:0] e);
    compares = compares + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Extra edge so decodes have landed on return
  task wr(input [7:0] a, input [7:0] d);
    {WR_EN, ADDR, WDATA} = {1'b1, a, d};
    step;
    WR_EN = 0;
    step;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    {RD_EN, ADDR} = {1'b1, a};
    step;
    RD_EN = 0;
    chk(RDATA, e);
    step;
  endtask
  task t_reset;
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    rd(8'h3e, 8'hc9);
    rd(8'h3f, 8'h80);
    chk(CH1_VOLUME_HALF_DB, 9'd200);
    chk(CH1_ANALOG_GAIN_TRIM_CODE, 9'd8);
  endtask
  task t_input;
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'hfd);
    chk(CH1_INPUT_KIND, 1'b1);
    // host pin setup assumed done outside this block
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h3c, {1'b0, i[1:0], 1'b1, i[1:0], 2'b00});
      chk(CH1_SOURCE_SELECT, i[1:0]);
      chk(CH1_IMPEDANCE_SELECT, i[1:0]);
      chk(CH1_COUPLING_SELECT, i != 2);
      chk(CH1_CONFIG_RESERVED, i == 3);
    end
  endtask
  task t_gain;
    wr(8'h3c, 8'h00);
    wr(8'h3d, 8'hab);
    rd(8'h3d, 8'ha8);
    chk(CH1_ANALOG_GAIN, 9'd42);
    chk(CH1_CONFIG_RESERVED, 1'b0);
    wr(8'h3d, 8'hfc);
    chk(CH1_ANALOG_GAIN, 9'd42);
    chk(CH1_CONFIG_RESERVED, 1'b1);
    wr(8'h3d, 8'h0c);
    chk(CH1_ANALOG_GAIN, 9'd3);
  endtask
  task vol(input [7:0] v, input [8:0] e);
    wr(8'h3e, v);
    rd(8'h3e, v);
    chk(CH1_MUTE, v == 8'h00);
    chk(CH1_VOLUME_HALF_DB, e);
  endtask
  task t_rerun;
    wr(8'h3e, 8'h00);
    RST = 1;
    step;
    RST = 0;
    rd(8'h3e, 8'hc9);
    chk(CH1_MUTE, 1'b0);
  endtask
  task t_trim;
    wr(8'h3f, 8'h0f);
    rd(8'h3f, 8'h00);
    chk(CH1_TRIM_TENTH_DB, 9'd0);
    wr(8'h3f, 8'hff);
    rd(8'h3f, 8'hf0);
    chk(CH1_TRIM_TENTH_DB, 9'd15);
    chk(CH1_ANALOG_GAIN_TRIM_CODE, 9'd15);
    wr(8'h40, 8'h55);
    rd(8'h40, 8'h00);
  endtask
  // Mode input crosses a two-flop synchroniser, hence three edges
  task t_mode;
    wr(8'h3c, 8'h01);
    chk(RANGE_ENHANCER_EN, 1'b1);
    chk(CH1_RANGE_GAIN_ENABLE, 1'b1);
    RANGE_GAIN_MODE_SEL = 1;
    repeat (3) step;
    chk(AUTOMATIC_GAIN_LOOP_EN, 1'b1);
    chk(RANGE_ENHANCER_EN, 1'b0);
  endtask
  task end_sim;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) step;
    RST = 0;
    t_reset;
    t_input;
    t_gain;
    vol(8'h00, 9'd0);
    vol(8'h01, 9'd0);
    vol(8'hc9, 9'd200);
    vol(8'hca, 9'd201);
    vol(8'hff, 9'd254);
    t_trim;
    t_mode;
    t_rerun;
    end_sim;
  end
endmodule
`default_nettype wire

// ---- sim/cfr_monitor.sv ----
// Purpose: port checker for the channel one config registers
// Assumes: decodes follow a write edge by one edge, so are sampled two edges on
// Notes:   mode enables are checked only as a pair
`timescale 1ns/1ps
`default_nettype none
module cfr_monitor (
  input wire logic MCLK, RST, WR_EN, RD_EN, CH1_INPUT_KIND, CH1_COUPLING_SELECT,
  input wire logic CH1_RANGE_GAIN_ENABLE, RANGE_ENHANCER_EN, AUTOMATIC_GAIN_LOOP_EN, CH1_MUTE,
  input wire logic [7:0] ADDR, WDATA, RDATA, CH1_VOLUME,
  input wire logic [1:0] CH1_SOURCE_SELECT,
  input wire logic [5:0] CH1_ANALOG_GAIN,
  input wire logic [8:0] CH1_VOLUME_HALF_DB
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // A lone write, so the decode two edges on is not overtaken
  sequence s_wr(a); WR_EN && ADDR == a ##1 !(WR_EN && ADDR == a); endsequence
  property p_mute; CH1_MUTE == (CH1_VOLUME == 8'h00); endproperty
  a_mute: assert property (p_mute) else $error("mute flag wrong");
  property p_half; !CH1_MUTE |-> CH1_VOLUME_HALF_DB == {1'b0, CH1_VOLUME} - 9'd1; endproperty
  a_half: assert property (p_half) else $error("volume step wrong");
  property p_gmax; CH1_ANALOG_GAIN <= 6'd42; endproperty
  a_gmax: assert property (p_gmax) else $error("gain above 42");
  property p_cpl; CH1_SOURCE_SELECT == 2'h2 |-> !CH1_COUPLING_SELECT; endproperty
  a_cpl: assert property (p_cpl) else $error("coupling on digital input");
  property p_mode; (RANGE_ENHANCER_EN | AUTOMATIC_GAIN_LOOP_EN) == CH1_RANGE_GAIN_ENABLE
    && !(RANGE_ENHANCER_EN && AUTOMATIC_GAIN_LOOP_EN); endproperty
  a_mode: assert property (p_mode) else $error("range or gain enable wrong");
  property p_cfg; s_wr(8'h3c) |=> {CH1_INPUT_KIND, CH1_SOURCE_SELECT, 4'h0,
    CH1_RANGE_GAIN_ENABLE} == ($past(WDATA, 2) & 8'he1); endproperty
  a_cfg: assert property (p_cfg) else $error("input config wrong");
  property p_vol; s_wr(8'h3e) |=> CH1_VOLUME == $past(WDATA, 2); endproperty
  a_vol: assert property (p_vol) else $error("volume not taken");
  property p_trim; RD_EN && ADDR == 8'h3f |=> RDATA[3:0] == 4'h0; endproperty
  a_trim: assert property (p_trim) else $error("trim low nibble set");
endmodule
bind cfr_channel_one_config cfr_monitor cfr_monitor_i (.*);
`default_nettype wire
